// file: src/swa_pkg.sv
// Package for the auxiliary SMI and wake aggregator: register offsets,
// field positions and reset values.
// Assumes an 8-bit register bus with byte offsets as printed.
package swa_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_SMI_EN1 = 8'hB4;
    localparam logic [7:0] OFF_SMI_EN2 = 8'hB5;
    localparam logic [7:0] OFF_SMI_ST1 = 8'hB6;
    localparam logic [7:0] OFF_SMI_ST2 = 8'hB7;
    localparam logic [7:0] OFF_RSVD_SB = 8'hB8;
    localparam logic [7:0] OFF_PIN_SEL = 8'hC0;
    localparam logic [7:0] OFF_FORCE_CHG = 8'hC1;
    localparam logic [7:0] OFF_RATE_SHD = 8'hC2;
    localparam logic [7:0] OFF_SER1_SHD = 8'hC3;
    localparam logic [7:0] OFF_SER2_SHD = 8'hC4;
    localparam logic [7:0] OFF_WAKE_CTL = 8'hC5;
    localparam logic [7:0] OFF_WAKE_ST = 8'hC6;
    // Own additions: interrupt status and mask
    localparam logic [7:0] OFF_IRQ_ST = 8'hD0;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hD1;
    // Field masks: writable bits, and the defined bits of status one
    localparam logic [7:0] MASK_EN1 = 8'h9E;
    localparam logic [7:0] MASK_EN2 = 8'h57;
    localparam logic [7:0] MASK_ST1 = 8'h9E;
    localparam logic [7:0] MASK_PIN = 8'h4A; // Bit 6 picks the infrared receive source
    localparam logic [7:0] MASK_RATE = 8'hDF;
    localparam logic [7:0] MASK_FIFO = 8'hCF;
    // Field positions
    localparam int BIT_KBC_ROUTE = 4;
    localparam int BIT_SMI_SERIRQ = 6;
    localparam int BIT_IR_FLAG = 2;
    localparam int BIT_IR_LOC = 6;
    localparam int BIT_FORCE0 = 0;
    localparam int BIT_WAKE = 0;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PIN = 8'h02;
    localparam logic [7:0] RST_FORCE = 8'h03;
    // Interrupt status bits
    localparam int IRQ_SMI = 0;
    localparam int IRQ_IR = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_W = 3;
endpackage : swa_pkg

// file: src/swa_bus_if.sv
// Interface carrying the register bus between the top and the decoder.
// Assumes one clock; strobes one cycle long.
`timescale 1ns/1ns
interface swa_bus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wrStb;
    logic rdStb;
    logic [14:0] hit; // One-hot register select
    modport master (output addr, output wdata, output wrStb, output rdStb, input hit);
    modport decoder (input addr, input wdata, input wrStb, input rdStb, output hit);
endinterface : swa_bus_if

// file: src/swa_addr_dec.sv
// Address decoder: turns the bus address into a one-hot select.
// Assumes the package offsets; unmapped addresses select nothing.
`timescale 1ns/1ns
module swa_addr_dec
    import swa_pkg::*;
(
    swa_bus_if.decoder bus
);
    // Offsets in select-bit order
    localparam logic [7:0] OFFS [15] = '{OFF_SMI_EN1, OFF_SMI_EN2, OFF_SMI_ST1,
        OFF_SMI_ST2, OFF_RSVD_SB, OFF_PIN_SEL, OFF_FORCE_CHG, OFF_RATE_SHD,
        OFF_SER1_SHD, OFF_SER2_SHD, OFF_WAKE_CTL, OFF_WAKE_ST, OFF_IRQ_ST,
        OFF_IRQ_MASK, 8'hFF};

    // Compare address against every offset; last slot never hits
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            bus.hit[i] = (i < 14) && (bus.addr == OFFS[i]);
        end
    end
endmodule : swa_addr_dec

// file: src/swa_top.sv
// Auxiliary SMI and wake aggregator: SMI gathering, forced media change,
// write-only shadows, wake-event control, local interrupt.
// Assumes peripheral requests are asynchronous levels; host is on core_clk.
`timescale 1ns/1ns
module swa_top
    import swa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn, // Main-supply reset, active low
    input wire logic standbyRstn, // Standby-supply reset, active low
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic printerReq,
    input wire logic serialOneReq,
    input wire logic serialTwoReq,
    input wire logic floppyReq,
    input wire logic watchdogReq,
    input wire logic mouseReq,
    input wire logic keyboardReq,
    input wire logic kbcLine,
    input wire logic serialTwoRx, // Serial two receive pin
    input wire logic altInfraredRx, // Alternate infrared receive pin
    input wire logic headStepN, // Floppy step output, active low
    input wire logic driveSelZeroN, // Drive select zero output, active low
    input wire logic mediaChangedInN, // Disk-change input pin (active low)
    input wire logic rateWrite, // Pulse: write-only rate register written
    input wire logic [7:0] rateWdata,
    input wire logic serOneFifoWrite, // Pulse: serial one FIFO control written
    input wire logic [7:0] serOneFifoWdata,
    input wire logic serTwoFifoWrite, // Pulse: serial two FIFO control written
    input wire logic [7:0] serTwoFifoWdata,
    input wire logic wakeEvent, // Level: device wake condition
    output logic sysMgmtIrqN, // Group SMI, active low
    output logic smiSerialFrame, // SMI level placed in serial IRQ frame
    output logic mediaChangedBit, // Disk-change bit for input register
    output logic wakeEventN, // Power-management event, active low
    output logic [7:0] pinFunctionSel,
    output logic irq // Local interrupt, active high
);
    // Reset synchronisers for both supplies
    logic rstMeta_q;
    logic rstSync_q;
    logic sbMeta_q;
    logic sbSync_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    always_ff @(posedge core_clk or negedge standbyRstn) begin
        if (!standbyRstn) begin
            sbMeta_q <= 1'b0;
            sbSync_q <= 1'b0;
        end else begin
            sbMeta_q <= 1'b1;
            sbSync_q <= sbMeta_q;
        end
    end
    logic rstnInt;
    logic sbRstnInt;
    assign rstnInt = rstSync_q;
    assign sbRstnInt = sbSync_q;

    // Two-flop synchronisers for all pin-level inputs
    localparam int NSYNC = 12;
    // Active-low pins reset to their idle high level, so no false edge follows reset
    localparam logic [NSYNC-1:0] PIN_IDLE = 12'h380;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] pinMeta_q;
    logic [NSYNC-1:0] pinSync_q;
    assign pinRaw = {altInfraredRx, serialTwoRx, mediaChangedInN, driveSelZeroN,
        headStepN, kbcLine, keyboardReq, mouseReq, watchdogReq, floppyReq,
        serialOneReq, serialTwoReq};
    logic printerMeta_q;
    logic printerSync_q;
    logic wakeMeta_q;
    logic wakeSync_q;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            pinMeta_q <= PIN_IDLE;
            pinSync_q <= PIN_IDLE;
            printerMeta_q <= 1'b0;
            printerSync_q <= 1'b0;
            wakeMeta_q <= 1'b0;
            wakeSync_q <= 1'b0;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            printerMeta_q <= printerReq;
            printerSync_q <= printerMeta_q;
            wakeMeta_q <= wakeEvent;
            wakeSync_q <= wakeMeta_q;
        end
    end
    logic sTwo, sOne, sFlop, sWdt, sMouse, sKbd, sKbc, sStepN, sDselN, sChgN;
    logic sRx2, sAltRx;
    assign {sAltRx, sRx2, sChgN, sDselN, sStepN, sKbc, sKbd, sMouse, sWdt, sFlop,
        sOne, sTwo} = pinSync_q;

    // Register bus decode through the small decoder module
    swa_bus_if bus ();
    assign bus.addr = regAddr;
    assign bus.wdata = regWdata;
    assign bus.wrStb = regWrite;
    assign bus.rdStb = regRead;
    swa_addr_dec uDec (
        .bus(bus)
    );
    function automatic logic wrHit(input int idx);
        wrHit = regWrite && bus.hit[idx];
    endfunction : wrHit

    // Control registers on main-supply reset
    logic [7:0] smiEnOne_q;
    logic [7:0] smiEnTwo_q;
    logic [7:0] pinSel_q;
    logic [IRQ_W-1:0] irqMask_q;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            smiEnOne_q <= RST_ZERO;
            smiEnTwo_q <= RST_ZERO;
            pinSel_q <= RST_PIN;
            irqMask_q <= '0;
        end else begin
            if (wrHit(0)) smiEnOne_q <= regWdata & MASK_EN1;
            if (wrHit(1)) smiEnTwo_q <= regWdata & MASK_EN2;
            if (wrHit(5)) pinSel_q <= regWdata & MASK_PIN;
            if (wrHit(13)) irqMask_q <= regWdata[IRQ_W-1:0];
        end
    end
    assign pinFunctionSel = pinSel_q;

    // Raw status views, cleared only when the source withdraws
    logic [7:0] stOne;
    assign stOne = {sWdt, 2'b00, sFlop, sOne, sTwo, printerSync_q, 1'b0};

    // Infrared source select and transition detect
    logic irPrev_q;
    logic irFlag_q;
    logic irMux;
    assign irMux = pinSel_q[BIT_IR_LOC] ? sAltRx : sRx2;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            irPrev_q <= 1'b0;
            irFlag_q <= 1'b0;
        end else begin
            irPrev_q <= irMux;
            // Set wins over the read clear so no edge is lost
            if (irMux != irPrev_q) irFlag_q <= 1'b1;
            else if (regRead && bus.hit[3]) irFlag_q <= 1'b0;
        end
    end
    logic [7:0] stTwo;
    assign stTwo = {3'b000, sKbc, 1'b0, irFlag_q, sKbd, sMouse};

    // Group SMI: any enabled status bit pulls it low
    logic smiAny;
    assign smiAny = |(stOne & smiEnOne_q) | |(stTwo & smiEnTwo_q & 8'h07)
        | (sKbc & smiEnTwo_q[BIT_KBC_ROUTE]);
    logic smiN_q;
    logic smiFrame_q;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            smiN_q <= 1'b1;
            smiFrame_q <= 1'b0;
        end else begin
            smiN_q <= ~smiAny;
            smiFrame_q <= smiAny & smiEnTwo_q[BIT_SMI_SERIRQ];
        end
    end
    assign sysMgmtIrqN = smiN_q;
    assign smiSerialFrame = smiFrame_q;

    // Forced media change latch; falling edges of step or select clear it
    logic force_q;
    logic stepPrev_q;
    logic dselPrev_q;
    logic chgBit_q;
    logic forceClr;
    assign forceClr = (stepPrev_q & ~sStepN) | (dselPrev_q & ~sDselN);
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            force_q <= RST_FORCE[BIT_FORCE0];
            stepPrev_q <= 1'b1;
            dselPrev_q <= 1'b1;
            chgBit_q <= 1'b0;
        end else begin
            stepPrev_q <= sStepN;
            dselPrev_q <= sDselN;
            // Software set wins over hardware clear
            if (wrHit(6) && regWdata[BIT_FORCE0]) force_q <= 1'b1;
            else if (forceClr) force_q <= 1'b0;
            chgBit_q <= (~sDselN & force_q) | ~sChgN;
        end
    end
    assign mediaChangedBit = chgBit_q;

    // Shadows of write-only registers
    logic [7:0] rateShd_q;
    logic [7:0] serOneShd_q;
    logic [7:0] serTwoShd_q;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            rateShd_q <= RST_ZERO;
            serOneShd_q <= RST_ZERO;
            serTwoShd_q <= RST_ZERO;
        end else begin
            if (rateWrite) rateShd_q <= rateWdata & MASK_RATE;
            if (serOneFifoWrite) serOneShd_q <= serOneFifoWdata & MASK_FIFO;
            if (serTwoFifoWrite) serTwoShd_q <= serTwoFifoWdata & MASK_FIFO;
        end
    end

    // Wake control and flag on the standby reset only
    logic wakeEn_q;
    logic wakeFlag_q;
    always_ff @(posedge core_clk or negedge sbRstnInt) begin
        if (!sbRstnInt) begin
            wakeEn_q <= 1'b0;
            wakeFlag_q <= 1'b0;
        end else begin
            if (wrHit(10)) wakeEn_q <= regWdata[BIT_WAKE];
            // Set wins over a write-one clear
            if (wakeSync_q) wakeFlag_q <= 1'b1;
            else if (wrHit(11) && regWdata[BIT_WAKE]) wakeFlag_q <= 1'b0;
        end
    end
    assign wakeEventN = ~(wakeFlag_q & wakeEn_q);

    // Local interrupt: sticky status, write one to clear, set wins
    logic [IRQ_W-1:0] irqSt_q;
    logic [IRQ_W-1:0] irqEv;
    logic smiPrev_q;
    logic wakePrev_q;
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            smiPrev_q <= 1'b0;
            wakePrev_q <= 1'b0;
        end else begin
            smiPrev_q <= smiAny;
            wakePrev_q <= wakeFlag_q;
        end
    end
    always_comb begin
        irqEv = '0;
        irqEv[IRQ_SMI] = smiAny & ~smiPrev_q;
        irqEv[IRQ_IR] = (irMux != irPrev_q);
        irqEv[IRQ_WAKE] = wakeFlag_q & ~wakePrev_q;
    end
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            irqSt_q <= '0;
        end else begin
            irqSt_q <= irqEv | (irqSt_q & ~(wrHit(12) ? regWdata[IRQ_W-1:0] : '0));
        end
    end
    assign irq = |(irqSt_q & irqMask_q);

    // Read data register: one cycle after the read strobe, else zero
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        unique case (1'b1)
            bus.hit[0]: rdMux = smiEnOne_q;
            bus.hit[1]: rdMux = smiEnTwo_q;
            bus.hit[2]: rdMux = stOne;
            bus.hit[3]: rdMux = stTwo;
            bus.hit[5]: rdMux = pinSel_q;
            bus.hit[6]: rdMux = {RST_FORCE[7:1], force_q}; // Upper bits hold their default
            bus.hit[7]: rdMux = rateShd_q;
            bus.hit[8]: rdMux = serOneShd_q;
            bus.hit[9]: rdMux = serTwoShd_q;
            bus.hit[10]: rdMux = {7'h00, wakeEn_q};
            bus.hit[11]: rdMux = {7'h00, wakeFlag_q};
            bus.hit[12]: rdMux = {5'h00, irqSt_q};
            bus.hit[13]: rdMux = {5'h00, irqMask_q};
            default: rdMux = 8'h00; // Unmapped and reserved read zero
        endcase
    end
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? rdMux : 8'h00;
        end
    end
endmodule : swa_top

// file: bench/swa_top_properties.sv
// Checker for the SMI and wake aggregator top: bus and output relations.
// Assumes a reg read answers one cycle later and writes land at the strobe edge.
`timescale 1ns/1ns
module swa_top_properties
    import swa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic smiSerialFrame,
    input wire logic wakeEventN
);
    // One clock domain, so one default clock and one disable
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_rd_idle;
        !regRead |=> regRdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_unmap;
        regRead && regAddr == 8'hB9 |=> regRdata == 8'h00;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    property p_rd_rsvd;
        regRead && regAddr == OFF_RSVD_SB |=> regRdata == 8'h00;
    endproperty
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved reg not zero");
    property p_st1;
        regRead && regAddr == OFF_SMI_ST1 |=> (regRdata & ~MASK_ST1) == 8'h00;
    endproperty
    a_st1: assert property (p_st1) else $error("status one reserved bits set");
    property p_st2;
        regRead && regAddr == OFF_SMI_ST2 |=> (regRdata & 8'hE8) == 8'h00;
    endproperty
    a_st2: assert property (p_st2) else $error("status two reserved bits set");
    property p_en2;
        regRead && regAddr == OFF_SMI_EN2 |=> (regRdata & ~MASK_EN2) == 8'h00;
    endproperty
    a_en2: assert property (p_en2) else $error("enable two reserved bits set");
    // Frame bit is registered behind the enable, hence the extra cycle
    property p_frame;
        regWrite && regAddr == OFF_SMI_EN2 && !regWdata[6] |=> ##1 !smiSerialFrame;
    endproperty
    a_frame: assert property (p_frame) else $error("frame kept with route off");
    property p_wake;
        regWrite && regAddr == OFF_WAKE_CTL && !regWdata[0] |=> ##1 wakeEventN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake asserted while disabled");
endmodule : swa_top_properties

bind swa_top swa_top_properties u_props (.core_clk(core_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .smiSerialFrame(smiSerialFrame), .wakeEventN(wakeEventN));

// file: bench/swa_host_model.sv
// Host chipset stand-in: watches the serial-frame SMI and the wake line.
// Assumes both lines are sampled on core_clk; it only listens.
`timescale 1ns/1ns
module swa_host_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic smiSerialFrame,
    input wire logic wakeEventN,
    output logic frameSeen, // Sticky: an SMI frame arrived
    output logic wakeSeen // Sticky: a wake request arrived
);
    // Sticky capture, so short pulses are not missed between polls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frameSeen <= 1'b0;
            wakeSeen <= 1'b0;
        end else begin
            frameSeen <= frameSeen | smiSerialFrame;
            wakeSeen <= wakeSeen | !wakeEventN;
        end
    end
endmodule : swa_host_model

// file: bench/testbench.sv
// Self-checking bench for the SMI and wake aggregator top.
// Assumes pin inputs reach the outputs within three edges.
`timescale 1ns/1ns
module testbench
    import swa_pkg::*;
;
    logic core_clk = 0, rstn = 0, standbyRstn = 0;
    logic [7:0] regAddr = 0, regWdata = 0, rateWdata = 0, serOneFifoWdata = 0;
    logic [7:0] serTwoFifoWdata = 0, req1 = 0, req2 = 0; // Requests by status bit
    logic regWrite = 0, regRead = 0, rateWrite = 0, serOneFifoWrite = 0;
    logic serTwoFifoWrite = 0, serialTwoRx = 0, altInfraredRx = 0, wakeEvent = 0;
    logic headStepN = 1, driveSelZeroN = 1, mediaChangedInN = 1;
    logic [7:0] regRdata, pinFunctionSel, d;
    logic sysMgmtIrqN, smiSerialFrame, mediaChangedBit, wakeEventN, irq;
    logic frameSeen, wakeSeen;
    int failures = 0, checked = 0, i;
    logic [7:0] rstA [11] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hC0, 8'hC1, 8'hC2,
        8'hC3, 8'hC4, 8'hC5};
    logic [7:0] rstE [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00,
        8'h00, 8'h00, 8'h00};

    swa_top dut (.core_clk, .rstn, .standbyRstn, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .printerReq(req1[1]), .serialTwoReq(req1[2]),
        .serialOneReq(req1[3]), .floppyReq(req1[4]), .watchdogReq(req1[7]),
        .mouseReq(req2[0]), .keyboardReq(req2[1]), .kbcLine(req2[4]), .serialTwoRx,
        .altInfraredRx, .headStepN, .driveSelZeroN, .mediaChangedInN, .rateWrite,
        .rateWdata, .serOneFifoWrite, .serOneFifoWdata, .serTwoFifoWrite,
        .serTwoFifoWdata, .wakeEvent, .sysMgmtIrqN, .smiSerialFrame, .mediaChangedBit,
        .wakeEventN, .pinFunctionSel, .irq);
    swa_host_model host (.core_clk, .rstn, .smiSerialFrame, .wakeEventN, .frameSeen,
        .wakeSeen);

    // Free-running 10 MHz clock
    initial forever #50 core_clk = ~core_clk;

    function automatic logic [7:0] onehot(input int b);
        return 8'h01 << b;
    endfunction : onehot

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chkb

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // Single-cycle strobes; the trailing edge keeps back-to-back calls legal
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe: sample mid-cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        chk(regRdata & m, e);
    endtask : rd

    // One source at a time: raise, gate off, withdraw
    task automatic smi_src(input logic s, input int b);
        wr(OFF_SMI_EN1, s ? 8'h00 : onehot(b));
        wr(OFF_SMI_EN2, s ? (onehot(b) | 8'h40) : 8'h00);
        if (s) req2[b] <= 1'b1;
        else req1[b] <= 1'b1;
        idle(6);
        chkb(sysMgmtIrqN, 1'b0);
        chkb(smiSerialFrame, s);
        rd(s ? OFF_SMI_ST2 : OFF_SMI_ST1, 8'hFF, onehot(b));
        wr(s ? OFF_SMI_EN2 : OFF_SMI_EN1, 8'h00);
        idle(2);
        chkb(sysMgmtIrqN, 1'b1);
        req1 <= 8'h00;
        req2 <= 8'h00;
        idle(6);
        rd(s ? OFF_SMI_ST2 : OFF_SMI_ST1, 8'hFF, 8'h00);
    endtask : smi_src

    task automatic end_of_test;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        idle(20000);
        failures++;
        end_of_test();
    end

    initial begin
        d = 8'($urandom(89626));
        idle(2);
        rstn <= 1'b1;
        standbyRstn <= 1'b1;
        idle(4);
        for (i = 0; i < 11; i++) rd(rstA[i], 8'hFF, rstE[i]);
        d = 8'($urandom);
        wr(OFF_SMI_EN1, d);
        rd(OFF_SMI_EN1, 8'hFF, d & MASK_EN1);
        d = 8'($urandom);
        wr(OFF_SMI_EN2, d);
        rd(OFF_SMI_EN2, 8'hFF, d & MASK_EN2);
        wr(OFF_IRQ_MASK, 8'h01);
        for (i = 0; i < 16; i++)
            if (((i < 8) ? MASK_ST1 : 8'h13) & onehot(i % 8)) smi_src(i >= 8, i % 8);
        chkb(frameSeen, 1'b1);
        // Local interrupt: pending, masked off, cleared
        chkb(irq, 1'b1);
        rd(OFF_IRQ_ST, 8'h01, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        idle(1);
        chkb(irq, 1'b0);
        wr(OFF_IRQ_ST, 8'hFF);
        wr(OFF_IRQ_MASK, 8'hFF);
        idle(1);
        chkb(irq, 1'b0);
        // Infrared edge flag, read-to-clear, unselected pin ignored
        serialTwoRx <= 1'b1;
        idle(6);
        rd(OFF_SMI_ST2, 8'h04, 8'h04);
        rd(OFF_SMI_ST2, 8'h04, 8'h00);
        altInfraredRx <= 1'b1;
        idle(6);
        rd(OFF_SMI_ST2, 8'h04, 8'h00);
        // Select the alternate pin; both sources high, so the switch is no edge
        wr(OFF_PIN_SEL, 8'h42);
        @(negedge core_clk);
        chk(pinFunctionSel, 8'h42);
        altInfraredRx <= 1'b0;
        idle(6);
        rd(OFF_SMI_ST2, 8'h04, 8'h04);
        // Forced media change latch
        driveSelZeroN <= 1'b0;
        idle(6);
        driveSelZeroN <= 1'b1;
        rd(OFF_FORCE_CHG, 8'h01, 8'h00);
        wr(OFF_FORCE_CHG, 8'h01);
        rd(OFF_FORCE_CHG, 8'h01, 8'h01);
        wr(OFF_FORCE_CHG, 8'h00);
        rd(OFF_FORCE_CHG, 8'h01, 8'h01);
        headStepN <= 1'b0;
        idle(6);
        headStepN <= 1'b1;
        rd(OFF_FORCE_CHG, 8'h01, 8'h00);
        mediaChangedInN <= 1'b0;
        idle(4);
        chkb(mediaChangedBit, 1'b1);
        mediaChangedInN <= 1'b1;
        idle(4);
        chkb(mediaChangedBit, 1'b0);
        // Shadows of the write-only registers
        rateWdata <= 8'($urandom);
        serOneFifoWdata <= 8'($urandom);
        serTwoFifoWdata <= 8'($urandom);
        {rateWrite, serOneFifoWrite, serTwoFifoWrite} <= 3'h7;
        idle(1);
        {rateWrite, serOneFifoWrite, serTwoFifoWrite} <= 3'h0;
        rd(OFF_RATE_SHD, 8'hFF, rateWdata & MASK_RATE);
        rd(OFF_SER1_SHD, 8'hFF, serOneFifoWdata & MASK_FIFO);
        rd(OFF_SER2_SHD, 8'hFF, serTwoFifoWdata & MASK_FIFO);
        // Wake event: gated flag, write-one clear, standby-only reset
        wakeEvent <= 1'b1;
        idle(6);
        chkb(wakeEventN, 1'b1);
        rd(OFF_WAKE_ST, 8'h01, 8'h01);
        wr(OFF_WAKE_CTL, 8'h01);
        idle(1);
        chkb(wakeEventN, 1'b0);
        wakeEvent <= 1'b0;
        idle(6);
        wr(OFF_WAKE_ST, 8'h00);
        rd(OFF_WAKE_ST, 8'h01, 8'h01);
        wr(OFF_WAKE_ST, 8'h01);
        idle(1);
        chkb(wakeEventN, 1'b1);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(4);
        rd(OFF_WAKE_CTL, 8'h01, 8'h01);
        rd(OFF_SMI_EN1, 8'hFF, 8'h00);
        standbyRstn <= 1'b0;
        idle(2);
        standbyRstn <= 1'b1;
        idle(4);
        rd(OFF_WAKE_CTL, 8'h01, 8'h00);
        // Unmapped and read-only writes are dropped
        wr(8'hB9, 8'($urandom));
        rd(8'hB9, 8'hFF, 8'h00);
        wr(OFF_SMI_ST1, 8'hFF);
        rd(OFF_SMI_ST1, 8'hFF, 8'h00);
        end_of_test();
    end
endmodule : testbench
